// ---- src/iod_defines.svh ----
// Constants for the indexed literal offset instruction decoder
//======================================================================
// Summary of operation
// RULE1: Extension on: access address below boundary is offset from frame_pointer.
// RULE2: Extended instructions and indexed mode stay off while ext_instr_enable is 0. Here only indexed mode is gated; the instructions still execute.
// RULE3: add_acc_indexed adds accumulator to byte at frame_pointer+offset, one cycle.
// RULE4: Destination bit 0 writes accumulator, 1 writes back to memory byte.
// RULE5: add_acc_indexed updates negative, overflow, carry, digit-carry and zero flags.
// RULE6: bit_set_indexed sets bit 0..7 of byte at frame_pointer+offset, flags unchanged.
// RULE7: fill_ones_indexed writes ffh to byte at frame_pointer+offset, flags unchanged.
// RULE8: fill_ones_indexed runs decode, read offset, process, write quarter-cycles.
// RULE9: Offset only when access bit is 0 and address at most 5fh.
// RULE10: Effective address is 12-bit frame_pointer plus zero-extended offset, wrapping.
//======================================================================
`ifndef IOD_DEFINES_SVH
`define IOD_DEFINES_SVH

// Opcode fields
`define IOD_ADD_OPC        6'h09
`define IOD_ADD_OPC_MSB    15
`define IOD_ADD_OPC_LSB    10
`define IOD_BITSET_OPC     4'h8
`define IOD_BITSET_OPC_MSB 15
`define IOD_BITSET_OPC_LSB 12
`define IOD_FILL_OPC       7'h34
`define IOD_FILL_OPC_MSB   15
`define IOD_FILL_OPC_LSB   9
`define IOD_DEST_BIT       9
`define IOD_ACCESS_BIT     8
`define IOD_BITSEL_MSB     11
`define IOD_BITSEL_LSB     9
`define IOD_FILE_MSB       7
`define IOD_FILE_LSB       0
`define IOD_BOUNDARY       8'h5f
`define IOD_FILL_VALUE     8'hff
`define IOD_ACC_HIGH_PAGE  4'hf

// Register offsets
`define IOD_REG_CTRL       4'h0
`define IOD_REG_FP         4'h1
`define IOD_REG_BSR        4'h2
`define IOD_REG_ACC        4'h3
`define IOD_REG_STATUS     4'h4
`define IOD_REG_EADDR      4'h5
`define IOD_REG_COUNT      4'h6

// Register fields and reset values
`define IOD_CTRL_EXT_BIT   0
`define IOD_EADDR_IDX_BIT  15
`define IOD_CTRL_RST       1'b0
`define IOD_FP_RST         12'h000
`define IOD_BSR_RST        4'h0
`define IOD_ACC_RST        8'h00

`endif

// ---- src/iod_pkg.sv ----
// Types shared by the indexed literal offset instruction decoder
package iod_pkg;

    typedef enum logic [2:0] {
        IOD_FETCH,
        IOD_Q1,
        IOD_Q2,
        IOD_Q3,
        IOD_Q4
    } iod_state_t;

    typedef enum logic [1:0] {
        IOD_OP_NONE,
        IOD_OP_ADD,
        IOD_OP_BITSET,
        IOD_OP_FILL
    } iod_op_t;

    // Flags in status register bit order 4..0
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } iod_flags_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } iod_mem_req_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } iod_bus_req_t;

endpackage

// ---- src/iod_alu.sv ----
// Eight-bit adder with status flags for the indexed add
`timescale 1ns/1ps
module iod_alu
    import iod_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    output logic [7:0]      sum,
    output iod_flags_t      flags
);

    logic [8:0] full;
    logic [4:0] low;

    always_comb
    begin
        full     = {1'b0, a} + {1'b0, b};
        low      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum      = full[7:0];
        flags.c  = full[8];                                       // RULE5
        flags.dc = low[4];                                        // RULE5
        flags.z  = (full[7:0] == 8'h00);                          // RULE5
        flags.n  = full[7];                                       // RULE5
        // Signed overflow: like signs in, unlike sign out
        flags.ov = (a[7] == b[7]) && (full[7] != a[7]);           // RULE5
    end

endmodule

// ---- src/iod_decode.sv ----
// Indexed literal offset decoder and executor, top level
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "iod_defines.svh"
module iod_decode
    import iod_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         instr_valid,
    input  wire logic [15:0]  instr_word,
    output logic              instr_ready,
    output iod_mem_req_t      mem_req,
    input  wire logic [7:0]   mem_rdata,
    input  wire iod_bus_req_t bus_req,
    output logic [15:0]       bus_rdata
);

    //==================================================================
    // State record
    //==================================================================
    typedef struct packed {
        iod_state_t   st;
        logic [15:0]  ir;
        iod_op_t      op;
        logic         ready;
        logic         ext_en;
        logic [11:0]  fp;
        logic [3:0]   bsr;
        logic [7:0]   acc;
        iod_flags_t   flags;
        logic [11:0]  ea;
        logic         idx;
        iod_mem_req_t mem;
        logic [15:0]  rdata;
        logic [15:0]  count;
    } iod_regs_t;

    iod_regs_t r_q;
    iod_regs_t r_d;

    logic       rst_meta_q;
    logic       rst_sync_q;
    logic [7:0] alu_sum;
    iod_flags_t alu_flags;

    //==================================================================
    // Reset release
    //==================================================================
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    //==================================================================
    // Helpers
    //==================================================================
    function automatic iod_op_t op_decode(input logic [15:0] w);
        if (w[`IOD_ADD_OPC_MSB:`IOD_ADD_OPC_LSB] == `IOD_ADD_OPC)
            op_decode = IOD_OP_ADD;
        else if (w[`IOD_BITSET_OPC_MSB:`IOD_BITSET_OPC_LSB]
                 == `IOD_BITSET_OPC)
            op_decode = IOD_OP_BITSET;
        else if (w[`IOD_FILL_OPC_MSB:`IOD_FILL_OPC_LSB] == `IOD_FILL_OPC)
            op_decode = IOD_OP_FILL;
        else
            op_decode = IOD_OP_NONE;
    endfunction

    // Indexed form only with extension on, access bit 0, low address
    function automatic logic is_indexed(input logic [15:0] w,
                                        input logic        ext);
        is_indexed = ext                                          // RULE2
                   && !w[`IOD_ACCESS_BIT]                         // RULE9
                   && (w[`IOD_FILE_MSB:`IOD_FILE_LSB]
                       <= `IOD_BOUNDARY);                         // RULE9
    endfunction

    function automatic logic [11:0] eff_addr(input logic [15:0] w,
                                             input logic        idx,
                                             input logic [11:0] fp,
                                             input logic [3:0]  bsr);
        logic [7:0] f;
        f = w[`IOD_FILE_MSB:`IOD_FILE_LSB];
        if (idx)
            eff_addr = fp + {4'h0, f};                            // RULE1 RULE10
        else if (w[`IOD_ACCESS_BIT])
            eff_addr = {bsr, f};
        else if (f <= `IOD_BOUNDARY)
            eff_addr = {4'h0, f};
        else
            eff_addr = {`IOD_ACC_HIGH_PAGE, f};
    endfunction

    iod_alu u_alu (
        .a     (r_q.acc),
        .b     (mem_rdata),
        .sum   (alu_sum),
        .flags (alu_flags)
    );

    //==================================================================
    // Next state
    //==================================================================
    always_comb
    begin
        logic [7:0] bitmask;
        r_d         = r_q;
        bitmask     = 8'h00;
        r_d.mem.rd  = 1'b0;
        r_d.mem.wr  = 1'b0;
        r_d.rdata   = 16'h0000;

        // Register port; reads answer one cycle later, unmapped read 0
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `IOD_REG_CTRL:   r_d.rdata = {15'h0000, r_q.ext_en};
                `IOD_REG_FP:     r_d.rdata = {4'h0, r_q.fp};
                `IOD_REG_BSR:    r_d.rdata = {12'h000, r_q.bsr};
                `IOD_REG_ACC:    r_d.rdata = {8'h00, r_q.acc};
                `IOD_REG_STATUS: r_d.rdata = {11'h000, r_q.flags};
                `IOD_REG_EADDR:  r_d.rdata = {r_q.idx, 3'h0, r_q.ea};
                `IOD_REG_COUNT:  r_d.rdata = r_q.count;
                default:         r_d.rdata = 16'h0000;
            endcase
        end
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `IOD_REG_CTRL:
                    r_d.ext_en = bus_req.wdata[`IOD_CTRL_EXT_BIT]; // RULE2
                `IOD_REG_FP:     r_d.fp    = bus_req.wdata[11:0];
                `IOD_REG_BSR:    r_d.bsr   = bus_req.wdata[3:0];
                `IOD_REG_ACC:    r_d.acc   = bus_req.wdata[7:0];
                `IOD_REG_STATUS: r_d.flags = bus_req.wdata[4:0];
                default:         ;
            endcase
        end

        // Quarter-cycle sequence; core updates win over software writes
        case (r_q.st)
            IOD_FETCH:
            begin
                if (instr_valid && r_q.ready)
                begin
                    r_d.ir    = instr_word;
                    r_d.op    = op_decode(instr_word);
                    r_d.ready = 1'b0;
                    r_d.st    = IOD_Q1;
                end
            end
            IOD_Q1:
            begin
                // Decode: form the target address
                r_d.idx      = is_indexed(r_q.ir, r_q.ext_en);
                r_d.ea       = eff_addr(r_q.ir, r_d.idx, r_q.fp, r_q.bsr);
                r_d.mem.addr = r_d.ea;
                r_d.mem.rd   = (r_q.op == IOD_OP_ADD)
                            || (r_q.op == IOD_OP_BITSET);
                r_d.st       = IOD_Q2;
            end
            IOD_Q2:
            begin
                // Read operand; fill needs no read, data lands next cycle
                r_d.st = IOD_Q3;                                  // RULE8
            end
            IOD_Q3:
            begin
                r_d.st = IOD_Q4;                                  // RULE8
                case (r_q.op)
                    IOD_OP_ADD:
                    begin
                        r_d.flags = alu_flags;                    // RULE5
                        if (r_q.ir[`IOD_DEST_BIT])
                        begin
                            r_d.mem.wr    = 1'b1;                 // RULE4
                            r_d.mem.wdata = alu_sum;              // RULE3
                        end
                        else
                            r_d.acc = alu_sum;                    // RULE4
                    end
                    IOD_OP_BITSET:
                    begin
                        bitmask = 8'h01 << r_q.ir[`IOD_BITSEL_MSB:
                                                  `IOD_BITSEL_LSB];
                        r_d.mem.wr    = 1'b1;
                        r_d.mem.wdata = mem_rdata | bitmask;      // RULE6
                    end
                    IOD_OP_FILL:
                    begin
                        r_d.mem.wr    = 1'b1;                     // RULE8
                        r_d.mem.wdata = `IOD_FILL_VALUE;          // RULE7
                    end
                    default: ;
                endcase
            end
            IOD_Q4:
            begin
                // Write lands this cycle; accept the next word after it
                r_d.count = r_q.count + 16'h0001;
                r_d.ready = 1'b1;
                r_d.st    = IOD_FETCH;
            end
            default:
            begin
                r_d.ready = 1'b1;
                r_d.st    = IOD_FETCH;
            end
        endcase
    end

    //==================================================================
    // State register
    //==================================================================
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            r_q        <= '0;
            r_q.st     <= IOD_FETCH;
            r_q.op     <= IOD_OP_NONE;
            r_q.ready  <= 1'b1;
            r_q.ext_en <= `IOD_CTRL_RST;                          // RULE2
            r_q.fp     <= `IOD_FP_RST;
            r_q.bsr    <= `IOD_BSR_RST;
            r_q.acc    <= `IOD_ACC_RST;
        end
        else if (ce)
        begin
            r_q <= r_d;
        end
    end

    assign instr_ready = r_q.ready;
    assign mem_req     = r_q.mem;
    assign bus_rdata   = r_q.rdata;

endmodule

// ---- dv/iod_decode_props.sv ----
// Checker for the indexed offset decoder top-level ports
`timescale 1ns/1ps
`include "iod_defines.svh"
module iod_decode_props
    import iod_pkg::*;
(
    input wire logic         mclk,
    input wire logic         resetn,
    input wire logic         ce,
    input wire logic         instr_valid,
    input wire logic [15:0]  instr_word,
    input wire logic         instr_ready,
    input wire iod_mem_req_t mem_req,
    input wire logic [7:0]   mem_rdata,
    input wire iod_bus_req_t bus_req,
    input wire logic [15:0]  bus_rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic take;
    logic is_add;
    logic is_bitset;
    logic is_fill;
    assign take    = instr_valid && instr_ready && ce;
    assign is_add  = instr_word[15:10] == `IOD_ADD_OPC;
    assign is_bitset = instr_word[15:12] == `IOD_BITSET_OPC;
    assign is_fill = instr_word[15:9] == `IOD_FILL_OPC;

    //==================================================================
    // Properties
    property p_busy_span;
        take |=> !instr_ready [*4] ##1 instr_ready;
    endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("instruction slot not five cycles");
    property p_add_read;
        take && is_add |-> ##2 mem_req.rd;
    endproperty
    a_add_read: assert property (p_add_read)
        else $error("indexed add did not read its operand");
    property p_add_dest_acc;
        take && is_add && !instr_word[9] |-> ##4 !mem_req.wr;
    endproperty
    a_add_dest_acc: assert property (p_add_dest_acc)
        else $error("add to accumulator wrote memory");
    property p_add_dest_mem;
        take && is_add && instr_word[9] |-> ##4 mem_req.wr;
    endproperty
    a_add_dest_mem: assert property (p_add_dest_mem)
        else $error("add to memory missed its write");
    property p_bitset_rmw;
        take && is_bitset |-> ##2 mem_req.rd ##2 mem_req.wr;
    endproperty
    a_bitset_rmw: assert property (p_bitset_rmw)
        else $error("bit set did not read then write");
    property p_fill_write;
        take && is_fill |-> ##2 !mem_req.rd ##2
            (mem_req.wr && mem_req.wdata == `IOD_FILL_VALUE);
    endproperty
    a_fill_write: assert property (p_fill_write)
        else $error("fill did not write all ones");
    property p_rd_pulse;
        mem_req.rd |=> !mem_req.rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("memory read longer than one cycle");
    property p_wr_pulse;
        mem_req.wr |=> !mem_req.wr && $stable(mem_req.addr);
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("memory write longer than one cycle");
    property p_bus_idle;
        !bus_req.rd |=> bus_rdata == 16'h0000;
    endproperty
    a_bus_idle: assert property (p_bus_idle)
        else $error("read data outside read slot");

    c_add: cover property (take && is_add);
    c_bitset: cover property (take && is_bitset);
    c_fill: cover property (take && is_fill);
endmodule

bind iod_decode iod_decode_props u_props (
    .mclk        (mclk),
    .resetn      (resetn),
    .ce          (ce),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .instr_ready (instr_ready),
    .mem_req     (mem_req),
    .mem_rdata   (mem_rdata),
    .bus_req     (bus_req),
    .bus_rdata   (bus_rdata)
);

// ---- dv/iod_mem_model.sv ----
// Data memory model on the far side of the decoder
`timescale 1ns/1ps
module iod_mem_model
    import iod_pkg::*;
(
    input  wire logic         mclk,
    input  wire iod_mem_req_t mem_req,
    output logic [7:0]        mem_rdata
);
    logic [7:0] mem [4096];

    initial mem_rdata = 8'h00;
    // Outside the read slot the bus toggles so stale data matches only on alternate cycles
    always @(posedge mclk)
    begin
        if (mem_req.wr)
            mem[mem_req.addr] <= mem_req.wdata;
        if (mem_req.rd)
            mem_rdata <= mem[mem_req.addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// ---- dv/iod_decode_tb_top.sv ----
// Self-checking testbench for the indexed offset decoder
`timescale 1ns/1ps
module iod_decode_tb_top;
    import iod_pkg::*;
    logic         mclk = 1'b0;
    logic         resetn = 1'b0;
    logic         ce = 1'b1;
    logic         instr_valid = 1'b0;
    logic [15:0]  instr_word = 16'h0000;
    logic         instr_ready;
    iod_mem_req_t mem_req;
    logic [7:0]   mem_rdata;
    iod_bus_req_t bus_req = '0;
    logic [15:0]  bus_rdata;
    int           errors = 0;
    int           num_checks = 0;

    always #2 mclk = ~mclk;

    iod_decode dut (.mclk(mclk), .resetn(resetn), .ce(ce),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .bus_req(bus_req), .bus_rdata(bus_rdata));
    iod_mem_model u_mem (.mclk(mclk), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    //==================================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask
    // Decoder is idle on entry, so the word is taken at the second edge
    task automatic exec(input logic [15:0] w);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 chk({15'h0000, instr_ready}, 16'h0001);
    endtask
    task automatic mchk(input logic [11:0] a, input logic [7:0] exp);
        chk({8'h00, u_mem.mem[a]}, {8'h00, exp});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    //==================================================================
    // Tests
    initial
    begin
        #20000;
        errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_rd(4'h0, 16'h0000);
        bus_rd(4'h1, 16'h0000);
        bus_rd(4'h3, 16'h0000);
        bus_rd(4'h7, 16'h0000);
        bus_wr(4'h1, 16'h0a00);
        bus_wr(4'h3, 16'h0017);
        u_mem.mem[12'h02c] = 8'h20;
        u_mem.mem[12'ha2c] = 8'h20;
        exec(16'h262c);
        mchk(12'h02c, 8'h37);
        mchk(12'ha2c, 8'h20);
        bus_rd(4'h5, 16'h002c);
        bus_wr(4'h0, 16'h0001);
        exec(16'h242c);
        bus_rd(4'h3, 16'h0037);
        mchk(12'ha2c, 8'h20);
        bus_rd(4'h5, 16'h8a2c);
        exec(16'h262c);
        mchk(12'ha2c, 8'h57);
        bus_wr(4'h3, 16'h0080);
        u_mem.mem[12'ha00] = 8'h80;
        exec(16'h2400);
        bus_rd(4'h3, 16'h0000);
        bus_rd(4'h4, 16'h000d);
        for (int b = 0; b < 8; b++)
        begin
            u_mem.mem[12'ha0a] = 8'h00;
            exec({4'h8, 3'(b), 1'b0, 8'h0a});
            mchk(12'ha0a, 8'h01 << b);
        end
        bus_rd(4'h4, 16'h000d);
        u_mem.mem[12'ha5f] = 8'h00;
        exec(16'h685f);
        mchk(12'ha5f, 8'hff);
        bus_rd(4'h4, 16'h000d);
        u_mem.mem[12'hf60] = 8'h00;
        exec(16'h6860);
        mchk(12'hf60, 8'hff);
        bus_wr(4'h2, 16'h0003);
        u_mem.mem[12'h310] = 8'h00;
        exec(16'h6910);
        mchk(12'h310, 8'hff);
        bus_wr(4'h1, 16'h0fff);
        u_mem.mem[12'h001] = 8'h00;
        exec(16'h6802);
        mchk(12'h001, 8'hff);
        bus_rd(4'h5, 16'h8001);
        bus_rd(4'h0, 16'h0001);
        bus_rd(4'h1, 16'h0fff);
        bus_rd(4'h2, 16'h0003);
        bus_rd(4'h6, 16'h0010);
        // Clock enable low: a software write must not land
        @(posedge mclk);
        ce <= 1'b0;
        bus_wr(4'h3, 16'h0055);
        @(posedge mclk);
        ce <= 1'b1;
        bus_rd(4'h3, 16'h0000);
        // Mid-run reset returns extension, pointer and count to zero
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_rd(4'h0, 16'h0000);
        bus_rd(4'h1, 16'h0000);
        bus_rd(4'h6, 16'h0000);
        tally_and_finish();
    end
endmodule
